// ===== bench/ddrx_chk.sv
// Assertions on the memory device pin interface
`timescale 1ns/10ps
`default_nettype none
module ddrx_chk
  import ddrx_pkg::*;
(
  input wire logic rstn,
  input wire logic sys_clk_diff,
  input wire logic clk_en,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic [BANK_W-1:0] bank_sel,
  input wire logic [ADDR_W-1:0] addr_bus,
  input wire logic data_bus_oe,
  input wire logic lo_byte_strobe_oe,
  input wire logic hi_byte_strobe_oe,
  input wire logic status_clk_gated,
  input wire logic status_bank_active,
  input wire logic status_mode_set
);
  logic [ADDR_W-1:0] mode_reg;
  wire take = clk_en && !chip_sel_n;
  wire [2:0] cmd = {row_strobe_n, col_strobe_n, write_en_n};
  wire rd_take = take && cmd == CMD_READ;
  wire rd_go = rd_take && !data_bus_oe;
  wire mode_wr = take && cmd == CMD_MODE && !bank_sel[EXT_SEL_BIT];
  wire cl2 = mode_reg[MODE_CL_LSB +: 3] == CL_CODE_2;
  // Track the latency and burst length the device should use
  always_ff @(posedge sys_clk_diff or negedge rstn)
    if (!rstn) mode_reg <= MODE_RESET;
    else if (mode_wr) mode_reg <= addr_bus;
  default clocking @(posedge sys_clk_diff); endclocking
  default disable iff (!rstn);
  sequence s_rise;
    !data_bus_oe ##1 data_bus_oe;
  endsequence
  a_strobe_oe:
    assert property (lo_byte_strobe_oe == data_bus_oe && hi_byte_strobe_oe == data_bus_oe)
      else $error("strobe enable differs from data enable");
  a_read_cl2:
    assert property (rd_go && cl2 |-> ##2 s_rise) else $error("latency two read late or early");
  a_read_cl3:
    assert property (rd_go && !cl2 |-> ##3 s_rise) else $error("latency three read wrong");
  a_oe_cause:
    assert property ($rose(data_bus_oe) |-> $past(rd_take, 3) || $past(rd_take, 4))
      else $error("data driven without accepted read");
  a_burst_two:
    assert property ($rose(data_bus_oe) && mode_reg[2:0] == BL_CODE_2 |=> !data_bus_oe)
      else $error("two word burst too long");
  a_mode_flag:
    assert property (mode_wr |-> ##[1:12] status_mode_set) else $error("mode flag missing");
  a_bank_flag:
    assert property (take && cmd == CMD_ACTIVATE |-> ##[1:12] status_bank_active)
      else $error("bank flag missing");
  a_gate_on:
    assert property (!clk_en [*8] ##1 !clk_en [*4] |-> status_clk_gated)
      else $error("gated flag missing");
  a_gate_off:
    assert property (clk_en [*8] ##1 clk_en [*4] |-> !status_clk_gated)
      else $error("gated flag stuck");
endmodule : ddrx_chk
bind ddrx_device ddrx_chk ddrx_chk_i (
  .rstn(rstn),
  .sys_clk_diff(sys_clk_diff),
  .clk_en(clk_en),
  .chip_sel_n(chip_sel_n),
  .row_strobe_n(row_strobe_n),
  .col_strobe_n(col_strobe_n),
  .write_en_n(write_en_n),
  .bank_sel(bank_sel),
  .addr_bus(addr_bus),
  .data_bus_oe(data_bus_oe),
  .lo_byte_strobe_oe(lo_byte_strobe_oe),
  .hi_byte_strobe_oe(hi_byte_strobe_oe),
  .status_clk_gated(status_clk_gated),
  .status_bank_active(status_bank_active),
  .status_mode_set(status_mode_set)
);
`default_nettype wire

// ===== bench/ddrx_ctl.sv
// Memory controller model: commands, clock enable and write bursts
`timescale 1ns/10ps
`default_nettype none
module ddrx_ctl
  import ddrx_pkg::*;
(
  input wire logic sys_clk_diff,
  output logic clk_en,
  output logic chip_sel_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_en_n,
  output logic [BANK_W-1:0] bank_sel,
  output logic [ADDR_W-1:0] addr_bus,
  output logic [DATA_W-1:0] dq,
  output logic dq_oe,
  output logic dqs,
  output logic lo_byte_mask,
  output logic hi_byte_mask
);
  initial begin
    {clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n} = 5'h1f;
    {bank_sel, addr_bus, dq, dq_oe, dqs, lo_byte_mask, hi_byte_mask} = '0;
  end
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                     input logic cs_n = 1'b0);
    @(posedge sys_clk_diff);
    {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, bank_sel, addr_bus} <= {cs_n, c, b, a};
    @(posedge sys_clk_diff);
    {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, addr_bus} <= {4'hf, ~a};
  endtask : cmd
  task automatic wr(input logic [1:0] b, input logic [11:0] col, input logic [15:0] w0, w1,
                    input logic [1:0] m1);
    cmd(CMD_WRITE, b, col);
    #24 {dq_oe, dq, hi_byte_mask, lo_byte_mask} <= {1'b1, w0, 2'h0};
    @(posedge sys_clk_diff) dqs <= 1'b1;
    #8 {dq, hi_byte_mask, lo_byte_mask} <= {w1, m1};
    #8 dqs <= 1'b0;
    #8 dq_oe <= 1'b0;
  endtask : wr
  task automatic pwr(input logic e);
    @(posedge sys_clk_diff);
    clk_en <= e;
  endtask : pwr
endmodule : ddrx_ctl
`default_nettype wire

// ===== bench/tb.sv
// Testbench for the memory device pin interface
`timescale 1ns/10ps
`default_nettype none
module tb
  import ddrx_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_clk_diff = 1'b0;
  logic rstn = 1'b0;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  wire clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, lo_byte_mask, hi_byte_mask;
  wire [1:0] bank_sel;
  wire [11:0] addr_bus;
  wire [15:0] dq, data_bus_i, data_bus_o;
  wire dq_oe, dqs, data_bus_oe, lo_byte_strobe_i, lo_byte_strobe_o, lo_byte_strobe_oe;
  wire hi_byte_strobe_i, hi_byte_strobe_o, hi_byte_strobe_oe;
  wire status_clk_gated, status_bank_active, status_mode_set;
  wire [3:0] strobes;
  assign strobes = {lo_byte_strobe_o, hi_byte_strobe_o, lo_byte_strobe_oe, hi_byte_strobe_oe};
  always #50 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #16 sys_clk_diff = ~sys_clk_diff;
  end
  // released lines show a moving pattern
  assign data_bus_i = dq_oe ? dq : (data_bus_oe ? data_bus_o : {16{sys_clk_diff}} ^ 16'h5a5a);
  assign lo_byte_strobe_i = dq_oe ? dqs : (lo_byte_strobe_oe ? lo_byte_strobe_o : sys_clk_diff);
  assign hi_byte_strobe_i = dq_oe ? dqs : (hi_byte_strobe_oe ? hi_byte_strobe_o : sys_clk_diff);
  ddrx_device ddrx_device_i (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sys_clk_diff(sys_clk_diff),
    .clk_en(clk_en),
    .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n),
    .write_en_n(write_en_n),
    .bank_sel(bank_sel),
    .addr_bus(addr_bus),
    .data_bus_i(data_bus_i),
    .data_bus_o(data_bus_o),
    .data_bus_oe(data_bus_oe),
    .lo_byte_strobe_i(lo_byte_strobe_i),
    .lo_byte_strobe_o(lo_byte_strobe_o),
    .lo_byte_strobe_oe(lo_byte_strobe_oe),
    .hi_byte_strobe_i(hi_byte_strobe_i),
    .hi_byte_strobe_o(hi_byte_strobe_o),
    .hi_byte_strobe_oe(hi_byte_strobe_oe),
    .lo_byte_mask(lo_byte_mask),
    .hi_byte_mask(hi_byte_mask),
    .status_clk_gated(status_clk_gated),
    .status_bank_active(status_bank_active),
    .status_mode_set(status_mode_set)
  );
  ddrx_ctl ddrx_ctl_i (
    .sys_clk_diff(sys_clk_diff),
    .clk_en(clk_en),
    .chip_sel_n(chip_sel_n),
    .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n),
    .write_en_n(write_en_n),
    .bank_sel(bank_sel),
    .addr_bus(addr_bus),
    .dq(dq),
    .dq_oe(dq_oe),
    .dqs(dqs),
    .lo_byte_mask(lo_byte_mask),
    .hi_byte_mask(hi_byte_mask)
  );
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [1:0] b, input logic [11:0] c, input logic [15:0] e0, e1,
                    input int cl);
    ddrx_ctl_i.cmd(CMD_READ, b, c);
    repeat (cl) @(posedge sys_clk_diff);
    #8 chk({data_bus_oe, data_bus_o}, {1'b1, e0});
    chk(strobes, 4'hf);
    #16 chk({data_bus_oe, data_bus_o}, {1'b1, e1});
    chk(strobes, 4'h3);
  endtask : rd
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #10 chk({status_clk_gated, status_bank_active, status_mode_set}, 3'h0);
    $display("test reset done");
    // open the bank before column access
    ddrx_ctl_i.cmd(CMD_ACTIVATE, 2'h1, 12'h005);
    repeat (12) @(posedge sys_clk_diff);
    chk(status_bank_active, 1'b1);
    ddrx_ctl_i.wr(2'h1, 12'h004, 16'h1111, 16'h2222, 2'h0);
    // High mask stays up through the reads
    ddrx_ctl_i.wr(2'h1, 12'h004, 16'haaaa, 16'hbbbb, 2'h2);
    rd(2'h1, 12'h004, 16'haaaa, 16'h22bb, 3);
    rd(2'h1, 12'h005, 16'h22bb, 16'haaaa, 3);
    $display("test masked write done");
    // Ignored read would drive in this half cycle
    ddrx_ctl_i.cmd(CMD_READ, 2'h1, 12'h004, 1'b1);
    repeat (3) @(posedge sys_clk_diff);
    #8 chk(data_bus_oe, 1'b0);
    ddrx_ctl_i.cmd(CMD_MODE, 2'h0, 12'h021);
    // Extended write must leave latency alone
    ddrx_ctl_i.cmd(CMD_MODE, 2'h1, 12'h031);
    ddrx_ctl_i.cmd(CMD_ACTIVATE, 2'h2, 12'h005);
    ddrx_ctl_i.wr(2'h2, 12'h004, 16'h3333, 16'h4444, 2'h0);
    rd(2'h1, 12'h004, 16'haaaa, 16'h22bb, 2);
    rd(2'h2, 12'h004, 16'h3333, 16'h4444, 2);
    chk(status_mode_set, 1'b1);
    // Four word interleaved burst at latency two
    ddrx_ctl_i.cmd(CMD_MODE, 2'h0, 12'h02a);
    rd(2'h1, 12'h005, 16'h22bb, 16'haaaa, 2);
    @(posedge sys_clk_diff) #8 chk(data_bus_oe, 1'b1);
    @(posedge sys_clk_diff) #8 chk(data_bus_oe, 1'b0);
    $display("test mode and banks done");
    // self refresh entered with clock enable low
    ddrx_ctl_i.pwr(1'b0);
    ddrx_ctl_i.cmd(CMD_REFRESH, 2'h0, 12'h000);
    // Read while the clock is gated is ignored
    ddrx_ctl_i.cmd(CMD_READ, 2'h2, 12'h004);
    repeat (2) @(posedge sys_clk_diff);
    #8 chk(data_bus_oe, 1'b0);
    repeat (16) @(posedge sys_clk_diff);
    chk(status_clk_gated, 1'b1);
    ddrx_ctl_i.pwr(1'b1);
    repeat (16) @(posedge sys_clk_diff);
    chk(status_clk_gated, 1'b0);
    rd(2'h2, 12'h005, 16'h4444, 16'h3333, 2);
    ddrx_ctl_i.cmd(CMD_PRECHARGE, 2'h0, 12'h400);
    repeat (12) @(posedge sys_clk_diff);
    chk(status_bank_active, 1'b0);
    $display("test power and precharge done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// ===== design/ddrx_device.sv
// Memory device logic behind the x16 double-data-rate pin interface
`timescale 1ns/10ps
`default_nettype none

module ddrx_device
  import ddrx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sys_clk_diff,
  input wire logic clk_en,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic [BANK_W-1:0] bank_sel,
  input wire logic [ADDR_W-1:0] addr_bus,
  input wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0] data_bus_o,
  output logic data_bus_oe,
  input wire logic lo_byte_strobe_i,
  output logic lo_byte_strobe_o,
  output logic lo_byte_strobe_oe,
  input wire logic hi_byte_strobe_i,
  output logic hi_byte_strobe_o,
  output logic hi_byte_strobe_oe,
  input wire logic lo_byte_mask,
  input wire logic hi_byte_mask,
  output logic status_clk_gated,
  output logic status_bank_active,
  output logic status_mode_set
);

  typedef struct packed {
    ddrx_pwr_t pwr;
    logic [ADDR_W-1:0] mode;
    logic [BANK_W-1:0] mode_bank;
    logic [ADDR_W-1:0] ext_mode;
    logic [BANK_W-1:0] ext_bank;
    logic mode_set;
    logic [NUM_BANKS-1:0] open;
    logic [NUM_BANKS*ROW_W-1:0] rows;
    logic wr_wait;
    logic [2:0] wr_left;
    logic [PAGE_W-1:0] wr_page;
    logic [COL_W-1:0] wr_col;
    logic [2:0] wr_idx;
    logic [1:0] rd_wait;
    logic [2:0] rd_left;
    logic [PAGE_W-1:0] rd_page;
    logic [COL_W-1:0] rd_col;
    logic [2:0] rd_idx;
    logic rd_drive;
  } ddrx_link_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } ddrx_sys_t;

  function automatic logic [2:0] bl_pairs(input logic [ADDR_W-1:0] mode);
    case (mode[MODE_BL_LSB +: 3])
      BL_CODE_2: bl_pairs = 3'h1;
      BL_CODE_4: bl_pairs = 3'h2;
      BL_CODE_8: bl_pairs = 3'h4;
      default: bl_pairs = 3'h4;
    endcase
  endfunction : bl_pairs

  // Column of a given beat within the burst
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [2:0] beat,
                                                 input logic [ADDR_W-1:0] mode);
    logic [COL_W-1:0] span;
    logic [COL_W-1:0] step;
    span = {{(COL_W-3){1'b0}}, (bl_pairs(mode) << 1) - 3'h1};
    if (mode[MODE_TYPE_BIT]) begin
      step = start ^ {{(COL_W-3){1'b0}}, beat};
    end else begin
      step = start + {{(COL_W-3){1'b0}}, beat};
    end
    burst_col = (start & ~span) | (step & span);
  endfunction : burst_col

  // flat index of bank, row, column
  function automatic logic [MEM_AW-1:0] mem_index(input logic [PAGE_W-1:0] page,
                                                  input logic [COL_W-1:0] start,
                                                  input logic [2:0] beat,
                                                  input logic [ADDR_W-1:0] mode);
    mem_index = {page, burst_col(start, beat, mode)};
  endfunction : mem_index

  ddrx_link_t ln_reg;
  ddrx_link_t ln_next;
  ddrx_sys_t sys_reg;
  ddrx_sys_t sys_next;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] cmd;
  logic [ROW_W-1:0] sel_row;
  logic [8:0] lo_rise;
  logic [8:0] hi_rise;
  logic [17:0] lo_pair;
  logic [17:0] hi_pair;
  logic [DATA_W-1:0] rise_q;
  logic [DATA_W-1:0] fall_pend;
  logic [DATA_W-1:0] fall_q;
  logic [DATA_W-1:0] mem [MEM_WORDS];

  assign cmd = {row_strobe_n, col_strobe_n, write_en_n};
  assign sel_row = ln_reg.rows[int'(bank_sel)*ROW_W +: ROW_W];

  always_comb begin
    ln_next = ln_reg;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    // internal clock runs only with enable high
    if (clk_en) begin
      ln_next.pwr = PWR_ACTIVE;
      if (ln_reg.wr_wait) begin
        ln_next.wr_wait = 1'b0;
      end else if (ln_reg.wr_left != 3'h0) begin
        wr_fire = 1'b1;
        ln_next.wr_left = ln_reg.wr_left - 3'h1;
        ln_next.wr_idx = ln_reg.wr_idx + 3'h2;
      end
      if (ln_reg.rd_wait != 2'h0) begin
        ln_next.rd_wait = ln_reg.rd_wait - 2'h1;
      end else if (ln_reg.rd_left != 3'h0) begin
        rd_fire = 1'b1;
        ln_next.rd_left = ln_reg.rd_left - 3'h1;
        ln_next.rd_idx = ln_reg.rd_idx + 3'h2;
      end
      ln_next.rd_drive = rd_fire;
      // decoder enabled by chip select low
      if (!chip_sel_n) begin
        case (cmd)
          CMD_MODE: begin
            if (bank_sel[EXT_SEL_BIT]) begin
              ln_next.ext_mode = addr_bus;
              ln_next.ext_bank = bank_sel;
            end else begin
              ln_next.mode = addr_bus;
              ln_next.mode_bank = bank_sel;
              ln_next.mode_set = 1'b1;
            end
          end
          CMD_PRECHARGE: begin
            if (addr_bus[PRE_ALL_BIT]) begin
              ln_next.open = '0;
            end else begin
              ln_next.open[bank_sel] = 1'b0;
            end
          end
          CMD_ACTIVATE: begin
            ln_next.open[bank_sel] = 1'b1;
            ln_next.rows[int'(bank_sel)*ROW_W +: ROW_W] = addr_bus[ROW_W-1:0];
          end
          CMD_WRITE: begin
            if (ln_reg.open[bank_sel]) begin
              ln_next.wr_wait = 1'b1;
              ln_next.wr_left = bl_pairs(ln_reg.mode);
              ln_next.wr_page = {bank_sel, sel_row};
              ln_next.wr_col = addr_bus[COL_W-1:0];
              ln_next.wr_idx = 3'h0;
              ln_next.rd_wait = 2'h0;
              ln_next.rd_left = 3'h0;
            end
          end
          CMD_READ: begin
            if (ln_reg.open[bank_sel]) begin
              ln_next.rd_wait = (ln_reg.mode[MODE_CL_LSB +: 3] == CL_CODE_2) ?
                                RD_WAIT_LOW : RD_WAIT_HIGH;
              ln_next.rd_left = bl_pairs(ln_reg.mode);
              ln_next.rd_page = {bank_sel, sel_row};
              ln_next.rd_col = addr_bus[COL_W-1:0];
              ln_next.rd_idx = 3'h0;
              ln_next.wr_wait = 1'b0;
              ln_next.wr_left = 3'h0;
            end
          end
          CMD_STOP: begin
            ln_next.rd_wait = 2'h0;
            ln_next.rd_left = 3'h0;
          end
          default: begin
            ln_next.open = ln_next.open;
          end
        endcase
      end
    end else begin
      if (!chip_sel_n && cmd == CMD_REFRESH) begin
        ln_next.pwr = PWR_SELF;
      end else if (ln_reg.pwr == PWR_ACTIVE) begin
        ln_next.pwr = PWR_DOWN;
      end
    end
  end

  always_ff @(posedge sys_clk_diff or negedge rstn) begin
    if (!rstn) begin
      ln_reg <= '0;
      ln_reg.pwr <= PWR_ACTIVE;
      ln_reg.mode <= MODE_RESET;
      ln_reg.ext_mode <= EXT_RESET;
    end else begin
      ln_reg <= ln_next;
    end
  end

  // data and mask on strobe edges
  always_ff @(posedge lo_byte_strobe_i or negedge rstn) begin
    if (!rstn) begin
      lo_rise <= '0;
    end else begin
      lo_rise <= {lo_byte_mask, data_bus_i[BYTE_W-1:0]};
    end
  end

  always_ff @(negedge lo_byte_strobe_i or negedge rstn) begin
    if (!rstn) begin
      lo_pair <= '0;
    end else begin
      lo_pair <= {lo_byte_mask, data_bus_i[BYTE_W-1:0], lo_rise};
    end
  end

  always_ff @(posedge hi_byte_strobe_i or negedge rstn) begin
    if (!rstn) begin
      hi_rise <= '0;
    end else begin
      hi_rise <= {hi_byte_mask, data_bus_i[DATA_W-1:BYTE_W]};
    end
  end

  always_ff @(negedge hi_byte_strobe_i or negedge rstn) begin
    if (!rstn) begin
      hi_pair <= '0;
    end else begin
      hi_pair <= {hi_byte_mask, data_bus_i[DATA_W-1:BYTE_W], hi_rise};
    end
  end

  always_ff @(posedge sys_clk_diff) begin
    if (wr_fire) begin
      if (!lo_pair[8]) begin
        mem[mem_index(ln_reg.wr_page, ln_reg.wr_col, ln_reg.wr_idx, ln_reg.mode)][7:0]
          <= lo_pair[7:0];
      end
      if (!hi_pair[8]) begin
        mem[mem_index(ln_reg.wr_page, ln_reg.wr_col, ln_reg.wr_idx, ln_reg.mode)][15:8]
          <= hi_pair[7:0];
      end
      if (!lo_pair[17]) begin
        mem[mem_index(ln_reg.wr_page, ln_reg.wr_col, ln_reg.wr_idx + 3'h1,
                      ln_reg.mode)][7:0] <= lo_pair[16:9];
      end
      if (!hi_pair[17]) begin
        mem[mem_index(ln_reg.wr_page, ln_reg.wr_col, ln_reg.wr_idx + 3'h1,
                      ln_reg.mode)][15:8] <= hi_pair[16:9];
      end
    end
  end

  always_ff @(posedge sys_clk_diff or negedge rstn) begin
    if (!rstn) begin
      rise_q <= '0;
      fall_pend <= '0;
    end else if (rd_fire) begin
      rise_q <= mem[mem_index(ln_reg.rd_page, ln_reg.rd_col, ln_reg.rd_idx, ln_reg.mode)];
      fall_pend <= mem[mem_index(ln_reg.rd_page, ln_reg.rd_col, ln_reg.rd_idx + 3'h1,
                                 ln_reg.mode)];
    end
  end

  always_ff @(negedge sys_clk_diff or negedge rstn) begin
    if (!rstn) begin
      fall_q <= '0;
    end else begin
      fall_q <= fall_pend;
    end
  end

  assign data_bus_o = sys_clk_diff ? rise_q : fall_q;
  assign data_bus_oe = ln_reg.rd_drive;
  assign lo_byte_strobe_o = sys_clk_diff & ln_reg.rd_drive;
  assign lo_byte_strobe_oe = ln_reg.rd_drive;
  assign hi_byte_strobe_o = sys_clk_diff & ln_reg.rd_drive;
  assign hi_byte_strobe_oe = ln_reg.rd_drive;

  // Status levels into the system clock domain
  always_comb begin
    sys_next = sys_reg;
    sys_next.s1 = {ln_reg.pwr != PWR_ACTIVE, |ln_reg.open, ln_reg.mode_set};
    sys_next.s2 = sys_reg.s1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sys_reg <= '0;
    end else begin
      sys_reg <= sys_next;
    end
  end

  assign status_clk_gated = sys_reg.s2[2];
  assign status_bank_active = sys_reg.s2[1];
  assign status_mode_set = sys_reg.s2[0];

endmodule : ddrx_device

`default_nettype wire

// ===== design/ddrx_pkg.sv
// Constants for the x16 double-data-rate memory device pin interface
`default_nettype none

package ddrx_pkg;
  localparam int ADDR_W = 12;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int BANK_WORDS = 2097152;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam int MEM_WORDS = NUM_BANKS * BANK_WORDS;
  localparam int PAGE_W = BANK_W + ROW_W;

  // Commands as {row strobe, column strobe, write enable}, all active low
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;

  // Field positions
  localparam int PRE_ALL_BIT = 10;
  localparam int EXT_SEL_BIT = 0;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_TYPE_BIT = 3;
  localparam int MODE_CL_LSB = 4;

  // Field codes
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_3 = 3'h3;

  // Read latency in clocks and the cycles to wait before the first pair
  localparam int CL_LOW = 2;
  localparam int CL_HIGH = 3;
  localparam logic [1:0] RD_WAIT_LOW = 2'(CL_LOW - 1);
  localparam logic [1:0] RD_WAIT_HIGH = 2'(CL_HIGH - 1);

  // Reset values
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h031;
  localparam logic [ADDR_W-1:0] EXT_RESET = 12'h000;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_DOWN = 3'b010,
    PWR_SELF = 3'b100
  } ddrx_pwr_t;
endpackage : ddrx_pkg

`default_nettype wire
